// ==== rtl/eeec_ctrl.sv ====
// Overview of operation
// - entry into an uninitialized container takes a protection fault
// - entry faults unless the thread control structure is idle
// - entry faults unless code, data, extra and stack bases are zero
// - entry faults when already in container mode
// - entry faults when the structure pointer is not page aligned
// - entry faults when a reserved flags bit is set
// - entry faults when fs or gs leaves the data segment or is misaligned
// - entry target must be canonical in 64-bit mode, else within code limit
// - without extended save, the mask must equal 3
// - with extended save, the mask must be a subset of the live register
// - bad structure or save-area pages give a page fault
// - with flow protection, save user state then load container values
// - debug opt-out entry clears the single-step trap flag
// - exit is leaf 04H, valid in both modes
// - exit branches to the target register and returns the async pointer
// - exit faults on bad target or when issued outside a container
// - exit into the container completes; next fetch returns fixed data
// - exit restores the extended control register if entry replaced it
// - opt-out exit reloads the trap flag and unsuppresses debug and counters
// - exit pends single-step if trap flag set, monitor trap if enabled
// - with shadow stacks on, exit records the pointer as previous pointer
// - exit restores flow state; with cfp_enable and saved end-branch bit set, tracking awaits target, suppress 0
`timescale 1ns/1ns
`default_nettype none
module eeec_ctrl
    import eeec_pkg::*;
#(
    parameter int ADDR_W = XLEN,
    parameter int VA_W = VA_BITS
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire logic [3:0] req_leaf,
    input wire eeec_entry_chk_t entry_chk,
    input wire eeec_core_t core,
    output logic req_ready,
    output eeec_result_t result,
    output logic container_mode
);
    if (ADDR_W != XLEN || VA_W >= ADDR_W) begin : g_bad_w
        $error("address widths not supported");
    end

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    typedef enum logic {ST_IDLE, ST_RESP} eeec_state_t;
    eeec_state_t state_reg;
    eeec_result_t result_reg;
    eeec_result_t result_next;
    logic container_mode_reg;
    logic accept;
    logic is_entry;
    logic is_exit;

    assign req_ready = (state_reg == ST_IDLE);
    assign accept = req_valid && req_ready;
    assign is_entry = (req_leaf == LEAF_ENTRY) || (req_leaf == LEAF_RESUME);
    assign is_exit = (req_leaf == LEAF_EXIT);
    assign result = result_reg;
    assign container_mode = container_mode_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (accept) begin
                        state_reg <= ST_RESP;
                    end
                end
                ST_RESP: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // fault checks
    // ----------------------------------------------------------------
    logic entry_tgt_ok;
    logic exit_tgt_ok;
    logic extended_state_mask_ok;
    logic entry_gp;
    logic entry_pf;
    logic exit_gp;
    logic entry_go;
    logic exit_go;

    eeec_target_chk #(.AW(ADDR_W), .VA(VA_W)) u_entry_tgt (
        .mode64(core.mode64),
        .target(entry_chk.target),
        .cs_limit(core.cs_limit),
        .ok(entry_tgt_ok)
    );

    eeec_target_chk #(.AW(ADDR_W), .VA(VA_W)) u_exit_tgt (
        .mode64(core.mode64),
        .target(core.target_pointer_register),
        .cs_limit(core.cs_limit),
        .ok(exit_tgt_ok)
    );

    always_comb begin
        if (core.extended_save_enable_bit) begin
            extended_state_mask_ok = ((core.extended_state_mask
                & core.extended_control_register)
                == core.extended_state_mask);
        end else begin
            extended_state_mask_ok = (core.extended_state_mask == EXTENDED_STATE_MASK_LEGACY);
        end
    end

    assign entry_gp = !entry_chk.initialized
        || !entry_chk.tcs_idle
        || !entry_chk.seg_bases_zero
        || container_mode_reg
        || !entry_chk.tcs_page_aligned
        || !entry_chk.flags_rsvd_zero
        || !entry_chk.fsgs_ok
        || !entry_tgt_ok
        || !core.fp_save_enable_bit
        || !extended_state_mask_ok;
    assign entry_pf = !entry_chk.tcs_valid || !entry_chk.ssa_pages_ok;
    assign exit_gp = !container_mode_reg || !exit_tgt_ok;
    assign entry_go = accept && is_entry && !entry_gp && !entry_pf;
    assign exit_go = accept && is_exit && !exit_gp;

    // ----------------------------------------------------------------
    // save registers
    // ----------------------------------------------------------------
    logic xcr_cap;
    logic cfp_cap;
    logic ssp_cap;
    logic tf_cap;
    logic [XLEN-1:0] xcr_saved;
    logic [XLEN-1:0] cfp_saved;
    logic [XLEN-1:0] ssp_saved;
    logic [XLEN-1:0] aep_saved;
    logic [1:0] tf_saved;
    logic xcr_replaced;

    assign xcr_cap = entry_go && core.extended_save_enable_bit;
    assign cfp_cap = entry_go && core.cfp_feature;
    assign ssp_cap = cfp_cap && core.shstk_feature;
    assign tf_cap = entry_go;

    eeec_save_reg #(.W(XLEN)) u_xcr_save (
        .clk(clk),
        .reset_n(reset_n),
        .capture(xcr_cap),
        .d(core.extended_control_register),
        .q(xcr_saved)
    );

    eeec_save_reg #(.W(XLEN)) u_cfp_save (
        .clk(clk),
        .reset_n(reset_n),
        .capture(cfp_cap),
        .d(core.user_flow_protect_register),
        .q(cfp_saved)
    );

    eeec_save_reg #(.W(XLEN)) u_ssp_save (
        .clk(clk),
        .reset_n(reset_n),
        .capture(ssp_cap),
        .d(core.shadow_stack_pointer),
        .q(ssp_saved)
    );

    eeec_save_reg #(.W(XLEN)) u_aep_save (
        .clk(clk),
        .reset_n(reset_n),
        .capture(entry_go),
        .d(core.counter_register),
        .q(aep_saved)
    );

    eeec_save_reg #(.W(2)) u_tf_save (
        .clk(clk),
        .reset_n(reset_n),
        .capture(tf_cap),
        .d({!entry_chk.debug_opt_in, core.single_step_trap_flag}),
        .q(tf_saved)
    );

    eeec_save_reg #(.W(1)) u_xcr_flag (
        .clk(clk),
        .reset_n(reset_n),
        .capture(entry_go),
        .d(core.extended_save_enable_bit),
        .q(xcr_replaced)
    );

    // ----------------------------------------------------------------
    // result of the instruction
    // ----------------------------------------------------------------
    logic tf_after_exit;
    logic [XLEN-1:0] cfp_after_exit;

    assign tf_after_exit = tf_saved[1] ? tf_saved[0]
        : core.single_step_trap_flag;

    always_comb begin
        cfp_after_exit = cfp_saved;
        if (core.cfp_enable && cfp_saved[CFP_ENDBR_BIT]) begin
            cfp_after_exit[CFP_TRK_BIT] = AWAIT_BRANCH_TARGET;
            cfp_after_exit[CFP_SUPP_BIT] = SUPPRESS_CLEAR;
        end
    end

    always_comb begin
        result_next = '0;
        result_next.done = 1'b1;
        if (is_entry) begin
            result_next.gp_fault = entry_gp;
            result_next.pf_fault = !entry_gp && entry_pf;
            if (entry_go) begin
                result_next.ip_write = 1'b1;
                result_next.ip_value = entry_chk.target;
                result_next.counter_write = 1'b1;
                result_next.counter_value = core.instruction_pointer;
                result_next.xcr_write = core.extended_save_enable_bit;
                result_next.xcr_value = core.extended_state_mask;
                result_next.cfp_write = core.cfp_feature;
                result_next.cfp_value = core.container_flow_value;
                result_next.ssp_write = core.cfp_feature
                    && core.shstk_feature;
                result_next.ssp_value = core.container_ssp;
                result_next.tf_write = !entry_chk.debug_opt_in;
                result_next.tf_value = 1'b0;
                result_next.suppress_debug = !entry_chk.debug_opt_in;
                result_next.pend_single_step = entry_chk.debug_opt_in
                    && core.single_step_trap_flag;
                result_next.pend_monitor_trap = entry_chk.debug_opt_in
                    && core.monitor_trap;
                result_next.flush_linear = 1'b1;
            end
        end else if (is_exit) begin
            result_next.gp_fault = exit_gp;
            if (!exit_gp) begin
                result_next.ip_write = 1'b1;
                result_next.ip_value = core.target_pointer_register;
                result_next.counter_write = 1'b1;
                result_next.counter_value = aep_saved;
                result_next.fixed_fetch = core.target_in_container;
                result_next.xcr_write = xcr_replaced;
                result_next.xcr_value = xcr_saved;
                result_next.tf_write = tf_saved[1];
                result_next.tf_value = tf_saved[0];
                result_next.unsuppress_debug = 1'b1;
                result_next.pend_single_step = tf_after_exit;
                result_next.pend_monitor_trap = core.monitor_trap;
                if (core.cfp_feature) begin
                    result_next.prev_ssp_write =
                        core.user_flow_protect_register[CFP_SHSTK_BIT];
                    result_next.prev_ssp_value =
                        core.shadow_stack_pointer;
                    result_next.cfp_write = 1'b1;
                    result_next.cfp_value = cfp_after_exit;
                    result_next.ssp_write = core.shstk_feature;
                    result_next.ssp_value = ssp_saved;
                end
                result_next.tcs_idle_thread_state = 1'b1;
                result_next.flush_linear = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            result_reg <= '0;
        end else if (accept) begin
            result_reg <= result_next;
        end else begin
            result_reg <= '0;
        end
    end

    // ----------------------------------------------------------------
    // container mode indicator
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            container_mode_reg <= 1'b0;
        end else if (entry_go) begin
            container_mode_reg <= 1'b1;
        end else if (exit_go) begin
            container_mode_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_entry_uninit;
        @(posedge clk) disable iff (!reset_n)
        accept && is_entry && !entry_chk.initialized |=>
            result.done && result.gp_fault && !result.ip_write
            && $stable(container_mode);
    endproperty
    a_entry_uninit: assert property (p_entry_uninit)
        else $error("entry into uninitialized container not refused");

    property p_entry_nested;
        @(posedge clk) disable iff (!reset_n)
        accept && is_entry && container_mode |=>
            result.gp_fault && !result.ip_write ##1 container_mode;
    endproperty
    a_entry_nested: assert property (p_entry_nested)
        else $error("nested entry not refused");

    property p_extended_state_mask_legacy;
        @(posedge clk) disable iff (!reset_n)
        accept && is_entry && !core.extended_save_enable_bit
            && core.extended_state_mask != EXTENDED_STATE_MASK_LEGACY |=> result.gp_fault;
    endproperty
    a_extended_state_mask_legacy: assert property (p_extended_state_mask_legacy)
        else $error("bad legacy mask accepted");

    property p_entry_tf_clear;
        @(posedge clk) disable iff (!reset_n)
        entry_go && !entry_chk.debug_opt_in |=>
            result.tf_write && !result.tf_value && container_mode;
    endproperty
    a_entry_tf_clear: assert property (p_entry_tf_clear)
        else $error("opt-out entry left trap flag");

    property p_exit_outside;
        @(posedge clk) disable iff (!reset_n)
        accept && is_exit && !container_mode |=>
            result.gp_fault && !result.ip_write && !result.tcs_idle_thread_state;
    endproperty
    a_exit_outside: assert property (p_exit_outside)
        else $error("exit outside container not refused");

    property p_exit_branch;
        @(posedge clk) disable iff (!reset_n)
        exit_go |=> result.ip_write
            && result.ip_value == $past(core.target_pointer_register)
            && result.counter_value == aep_saved;
    endproperty
    a_exit_branch: assert property (p_exit_branch)
        else $error("exit target or async pointer wrong");

    property p_xcr_restore;
        @(posedge clk) disable iff (!reset_n)
        xcr_cap ##1 (!entry_go)[*2] ##0 exit_go |=>
            result.xcr_write
            && result.xcr_value == $past(core.extended_control_register, 3);
    endproperty
    a_xcr_restore: assert property (p_xcr_restore)
        else $error("extended control register not restored");

    property p_tf_restore;
        @(posedge clk) disable iff (!reset_n)
        exit_go && tf_saved[1] |=> result.tf_write
            && result.tf_value == $past(tf_saved[0])
            && result.unsuppress_debug;
    endproperty
    a_tf_restore: assert property (p_tf_restore)
        else $error("opt-out exit trap flag not reloaded");

    property p_pend_step;
        @(posedge clk) disable iff (!reset_n)
        exit_go |=> result.pend_single_step == $past(tf_after_exit)
            && result.pend_monitor_trap == $past(core.monitor_trap);
    endproperty
    a_pend_step: assert property (p_pend_step)
        else $error("exit pending events wrong");

    property p_tracker;
        @(posedge clk) disable iff (!reset_n)
        exit_go && core.cfp_feature && core.cfp_enable
            && cfp_saved[CFP_ENDBR_BIT] |=>
            result.cfp_value[CFP_TRK_BIT] == AWAIT_BRANCH_TARGET
            && result.cfp_value[CFP_SUPP_BIT] == SUPPRESS_CLEAR;
    endproperty
    a_tracker: assert property (p_tracker)
        else $error("branch tracker not reset on exit");

    property p_exit_clear;
        @(posedge clk) disable iff (!reset_n)
        exit_go |=> !container_mode && result.tcs_idle_thread_state
            && result.flush_linear ##1 !result.done;
    endproperty
    a_exit_clear: assert property (p_exit_clear)
        else $error("exit did not leave container mode");
endmodule : eeec_ctrl
`default_nettype wire

// ==== common/eeec_pkg.sv ====
`default_nettype none
package eeec_pkg;
    // ----------------------------------------------------------------
    // widths and leaves
    // ----------------------------------------------------------------
    localparam int XLEN = 64;
    localparam int VA_BITS = 48;
    localparam int LIM_W = 32;
    localparam logic [3:0] LEAF_ENTRY = 4'h2;
    localparam logic [3:0] LEAF_RESUME = 4'h3;
    localparam logic [3:0] LEAF_EXIT = 4'h4;
    localparam logic [XLEN-1:0] EXTENDED_STATE_MASK_LEGACY = 64'h3;

    // ----------------------------------------------------------------
    // flow protect register fields
    // ----------------------------------------------------------------
    localparam int CFP_SHSTK_BIT = 0;
    localparam int CFP_ENDBR_BIT = 2;
    localparam int CFP_SUPP_BIT = 10;
    localparam int CFP_TRK_BIT = 11;
    localparam logic AWAIT_BRANCH_TARGET = 1'b1;
    localparam logic SUPPRESS_CLEAR = 1'b0;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic initialized;
        logic tcs_idle;
        logic seg_bases_zero;
        logic tcs_page_aligned;
        logic flags_rsvd_zero;
        logic fsgs_ok;
        logic tcs_valid;
        logic ssa_pages_ok;
        logic debug_opt_in;
        logic [XLEN-1:0] target;
    } eeec_entry_chk_t;

    typedef struct packed {
        logic mode64;
        logic [LIM_W-1:0] cs_limit;
        logic fp_save_enable_bit;
        logic extended_save_enable_bit;
        logic cfp_feature;
        logic shstk_feature;
        logic cfp_enable;
        logic monitor_trap;
        logic single_step_trap_flag;
        logic target_in_container;
        logic [XLEN-1:0] extended_control_register;
        logic [XLEN-1:0] extended_state_mask;
        logic [XLEN-1:0] user_flow_protect_register;
        logic [XLEN-1:0] container_flow_value;
        logic [XLEN-1:0] shadow_stack_pointer;
        logic [XLEN-1:0] container_ssp;
        logic [XLEN-1:0] target_pointer_register;
        logic [XLEN-1:0] counter_register;
        logic [XLEN-1:0] instruction_pointer;
    } eeec_core_t;

    typedef struct packed {
        logic done;
        logic gp_fault;
        logic pf_fault;
        logic ip_write;
        logic [XLEN-1:0] ip_value;
        logic counter_write;
        logic [XLEN-1:0] counter_value;
        logic xcr_write;
        logic [XLEN-1:0] xcr_value;
        logic cfp_write;
        logic [XLEN-1:0] cfp_value;
        logic ssp_write;
        logic [XLEN-1:0] ssp_value;
        logic prev_ssp_write;
        logic [XLEN-1:0] prev_ssp_value;
        logic tf_write;
        logic tf_value;
        logic pend_single_step;
        logic pend_monitor_trap;
        logic suppress_debug;
        logic unsuppress_debug;
        logic tcs_idle_thread_state;
        logic flush_linear;
        logic fixed_fetch;
    } eeec_result_t;
endpackage : eeec_pkg
`default_nettype wire

// ==== rtl/eeec_save_reg.sv ====
`timescale 1ns/1ns
`default_nettype none
module eeec_save_reg
    import eeec_pkg::*;
#(
    parameter int W = XLEN
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic capture,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    if (W < 1) begin : g_bad_w
        $error("save register width must be positive");
    end

    // ----------------------------------------------------------------
    // holding register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else if (capture) begin
            q <= d;
        end
    end
endmodule : eeec_save_reg
`default_nettype wire

// ==== rtl/eeec_target_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module eeec_target_chk
    import eeec_pkg::*;
#(
    parameter int AW = XLEN,
    parameter int VA = VA_BITS
) (
    input wire logic mode64,
    input wire logic [AW-1:0] target,
    input wire logic [LIM_W-1:0] cs_limit,
    output logic ok
);
    if (VA < 2 || VA > AW || AW <= LIM_W) begin : g_bad_va
        $error("target check widths out of range");
    end

    // ----------------------------------------------------------------
    // canonical or segment limit test
    // ----------------------------------------------------------------
    logic canon;
    logic in_limit;
    assign canon = (&target[AW-1:VA-1]) | ~(|target[AW-1:VA-1]);
    assign in_limit = ~(|target[AW-1:LIM_W])
        && (target[LIM_W-1:0] <= cs_limit);
    assign ok = mode64 ? canon : in_limit;
endmodule : eeec_target_chk
`default_nettype wire

// ==== verif/eeec_ctrl_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module eeec_ctrl_tb_top
    import eeec_pkg::*;
;
    logic clk;
    logic reset_n;
    logic req_valid;
    logic [3:0] req_leaf;
    eeec_entry_chk_t ec;
    eeec_core_t co;
    logic req_ready;
    logic cm;
    eeec_result_t r;
    eeec_result_t res;
    int fails;
    int checks;

    eeec_ctrl dut (
        .clk(clk),
        .reset_n(reset_n),
        .req_valid(req_valid),
        .req_leaf(req_leaf),
        .entry_chk(ec),
        .core(co),
        .req_ready(req_ready),
        .result(r),
        .container_mode(cm)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [64:0] seen, input logic [64:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one request, capture the done cycle
    task automatic go(input logic [3:0] leaf);
        int n;
        n = 0;
        req_leaf = leaf;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        while (r.done !== 1'b1) begin
            n++;
            if (n > 4) begin
                fails++;
                results();
            end
            @(negedge clk);
        end
        res = r;
        @(negedge clk);
    endtask : go

    task automatic base();
        ec = {9'h1FE, 64'h0000_0000_0040_1000};
        co = '{default: '0, mode64: 1'b1, cs_limit: 32'hFFFF_FFFF,
            fp_save_enable_bit: 1'b1, extended_save_enable_bit: 1'b1,
            cfp_feature: 1'b1, shstk_feature: 1'b1, cfp_enable: 1'b1,
            single_step_trap_flag: 1'b1, extended_control_register: 64'h7,
            extended_state_mask: 64'h3, user_flow_protect_register: 64'h405,
            container_flow_value: 64'h1, shadow_stack_pointer: 64'hA000,
            container_ssp: 64'hB000, target_pointer_register: 64'h2000,
            counter_register: 64'h5000, instruction_pointer: 64'h3000};
    endtask : base

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_entry_faults();
        for (int i = 0; i < 13; i++) begin
            base();
            if (i < 8) begin
                ec[72-i] = 1'b0;
            end
            case (i)
                8: co.fp_save_enable_bit = 1'b0;
                9: begin
                    co.extended_save_enable_bit = 1'b0;
                    co.extended_state_mask = 64'h7;
                end
                10: co.extended_state_mask = 64'hF;
                11: ec.target = 64'h0000_8000_0000_0000;
                12: begin
                    co.mode64 = 1'b0;
                    co.cs_limit = 32'h0000_FFFF;
                    ec.target = 64'h0001_0000;
                end
                default: ;
            endcase
            go(LEAF_ENTRY);
            chk(res.gp_fault, (i < 6 || i > 7));
            chk(res.pf_fault, (i == 6 || i == 7));
            chk({res.ip_write, cm}, 2'b00);
        end
        $display("entry faults done");
    endtask : t_entry_faults

    task automatic t_entry_ok();
        base();
        go(LEAF_ENTRY);
        chk({res.gp_fault, res.pf_fault, res.ip_write, cm}, 4'b0011);
        chk(res.ip_value, 64'h0040_1000);
        chk(res.counter_value, 64'h3000);
        chk({res.xcr_write, res.xcr_value}, {1'b1, 64'h3});
        chk({res.cfp_write, res.cfp_value}, {1'b1, 64'h1});
        chk({res.ssp_write, res.ssp_value}, {1'b1, 64'hB000});
        chk({res.tf_write, res.tf_value, res.suppress_debug}, 3'b101);
        go(LEAF_ENTRY);
        chk({res.gp_fault, res.ip_write, cm}, 3'b101);
        $display("entry done");
    endtask : t_entry_ok

    task automatic t_exit();
        base();
        co.target_pointer_register = 64'h0000_8000_0000_0000;
        go(LEAF_EXIT);
        chk({res.gp_fault, res.ip_write, cm}, 3'b101);
        co.target_pointer_register = 64'h2000;
        co.user_flow_protect_register = 64'h1;
        co.shadow_stack_pointer = 64'hB100;
        co.monitor_trap = 1'b1;
        co.single_step_trap_flag = 1'b0;
        co.target_in_container = 1'b1;
        go(LEAF_EXIT);
        chk({res.gp_fault, res.ip_write, res.fixed_fetch}, 3'b011);
        chk(res.ip_value, 64'h2000);
        chk(res.counter_value, 64'h5000);
        chk({res.xcr_write, res.xcr_value}, {1'b1, 64'h7});
        chk({res.tf_write, res.tf_value, res.unsuppress_debug}, 3'b111);
        chk({res.pend_single_step, res.pend_monitor_trap}, 2'b11);
        chk({res.prev_ssp_write, res.prev_ssp_value}, {1'b1, 64'hB100});
        chk(res.cfp_value, 64'h805);
        chk(res.ssp_value, 64'hA000);
        chk({res.tcs_idle_thread_state, res.flush_linear, cm}, 3'b110);
        go(LEAF_EXIT);
        chk({res.gp_fault, res.ip_write, cm}, 3'b100);
        chk(req_ready, 1'b1);
        $display("exit done");
    endtask : t_exit

    task automatic t_resume_optin();
        base();
        ec.debug_opt_in = 1'b1;
        co.monitor_trap = 1'b1;
        co.counter_register = 64'h6000;
        go(LEAF_RESUME);
        chk({res.gp_fault, res.ip_write, cm, res.tf_write}, 4'b0110);
        chk({res.suppress_debug, res.pend_single_step}, 2'b01);
        chk({res.pend_monitor_trap, res.flush_linear}, 2'b11);
        co.extended_control_register = 64'h1F;
        co.single_step_trap_flag = 1'b0;
        co.monitor_trap = 1'b0;
        co.cfp_enable = 1'b0;
        go(LEAF_EXIT);
        chk({res.gp_fault, res.tf_write, res.fixed_fetch}, 3'b000);
        chk(res.counter_value, 64'h6000);
        chk({res.xcr_write, res.xcr_value}, {1'b1, 64'h7});
        chk({res.pend_single_step, res.pend_monitor_trap}, 2'b00);
        chk(res.cfp_value, 64'h405);
        chk({res.tcs_idle_thread_state, cm}, 2'b10);
        go(4'h1);
        chk({res.gp_fault, res.pf_fault, res.ip_write, cm}, 4'b0000);
        $display("resume done");
    endtask : t_resume_optin

    initial begin
        fails = 0;
        checks = 0;
        reset_n = 1'b0;
        req_valid = 1'b0;
        req_leaf = 4'h0;
        base();
        repeat (6) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        t_entry_faults();
        t_entry_ok();
        t_exit();
        t_resume_optin();
        results();
    end
endmodule : eeec_ctrl_tb_top
`default_nettype wire
